/* File: pkg/bcr_pkg.sv */
// bar code serial receiver: shared constants, config layout, bus carriers and states
// assumes a single 100 MHz core clock and a 12-bit AXI4-Lite register window
`default_nettype none
package bcr_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_LO = 4800;
	localparam int BAUD_MID = 9600;
	localparam int BAUD_HI = 19200;
	localparam int BIT_CYC_LO = CLK_HZ / BAUD_LO;
	localparam int BIT_CYC_MID = CLK_HZ / BAUD_MID;
	localparam int BIT_CYC_HI = CLK_HZ / BAUD_HI;
	// ==========================================================
	// framing
	localparam logic [7:0] STX_CHAR = 8'h02;
	localparam logic [7:0] ETX_CHAR = 8'h03;
	localparam logic [7:0] CHAR_MIN = 8'h20;
	localparam logic [7:0] CHAR_MAX = 8'h7F;
	localparam int MAX_LEN = 40;
	// ==========================================================
	// register map and fields
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_ACK = 12'h008;
	localparam logic [3:0] OFS_STR_PAGE = 4'h1;
	localparam int ST_VALID = 0;
	localparam int ST_RTS = 1;
	localparam int ST_CTS = 2;
	localparam int ST_DISCARD = 3;
	localparam int ST_OVERRUN = 4;
	localparam int ST_LINE_ERR = 5;
	localparam int ST_COPY = 6;
	localparam int ST_LEN_LSB = 8;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] BAUD_SEL_LO = 2'h0;
	localparam logic [1:0] BAUD_SEL_MID = 2'h1;
	localparam logic [1:0] BAUD_SEL_HI = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic auto_mode;
		logic [1:0] baud;
		logic [1:0] parity;
		logic two_stop;
		logic eight_bits;
		logic enable;
	} bcr_cfg_s;
	// manual, 9600, even parity, 2 stop, 7 bits, port not selected
	localparam bcr_cfg_s CFG_RST = 8'h34;
	// ==========================================================
	// bus carriers
	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} bcr_axi_m_s;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bcr_axi_s_s;
	// ==========================================================
	// states
	typedef enum logic [2:0] {U_IDLE, U_START, U_DATA, U_PAR, U_STOP} bcr_uart_e;
	typedef enum logic {F_HUNT, F_TAKE} bcr_frm_e;
endpackage
`default_nettype wire

/* File: src/bcr_rx.sv */
// bar code serial receiver: line receiver, byte fifo, frame checker, string store, AXI4-Lite
// assumes rxd_in and cts_in are already synchronous to core_clk
//
// Operation
// - 7 or 8 data bits, 1 or 2 stop, none/odd/even parity; default 7/2/even.
// - baud 4800, 9600 or 19200; default 9600.
// - drive request-to-send toward the reader while reading bar codes.
// - manual or auto trigger, manual default; auto drops request-to-send until reported.
// - keep receiving if clear-to-send stays on; new string overwrites held one.
// - frame is STX, data characters, then ETX.
// - only bytes 0x20 to 0x7F are valid data characters.
// - at most forty data characters per frame.
// - discard frames with missing delimiter, bad character or excess length.
// - deliver each valid frame as a string into the string store.
// - receive only while the port is selected for bar code reader use.
`default_nettype none

// ==========================================================
// byte fifo
module bcr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_ff;
	logic [AW:0] rp_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
	assign out_valid = wp_ff != rp_ff;
	assign out_data = mem[rp_ff[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (push) mem[wp_ff[AW-1:0]] <= in_data;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			wp_ff <= wp_ff + (AW+1)'(push);
			rp_ff <= rp_ff + (AW+1)'(pop);
		end
	end
endmodule

// ==========================================================
// receiver top
module bcr_rx
	import bcr_pkg::*;
#(
	parameter int BIT_CYC_4800 = bcr_pkg::BIT_CYC_LO,
	parameter int BIT_CYC_9600 = bcr_pkg::BIT_CYC_MID,
	parameter int BIT_CYC_19200 = bcr_pkg::BIT_CYC_HI,
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register bus
	input wire bcr_pkg::bcr_axi_m_s axi_m,
	output bcr_pkg::bcr_axi_s_s axi_s,
	// reader link
	input wire logic rxd_in,
	input wire logic cts_in,
	output logic request_to_send_out
);
	// the bit counter is 16 bits wide and needs at least four cycles per bit
	if (BIT_CYC_4800 < 4 || BIT_CYC_4800 > 65535 ||
		BIT_CYC_9600 < 4 || BIT_CYC_9600 > 65535 ||
		BIT_CYC_19200 < 4 || BIT_CYC_19200 > 65535) begin : g_bad_bit_cyc
		$error("bit period out of range");
	end

	// ==========================================================
	// configuration and state registers
	bcr_cfg_s cfg_ff;
	bcr_axi_s_s axi_ff;
	logic rts_ff;
	logic str_valid_ff;
	logic discard_ff;
	logic overrun_ff;
	logic line_err_ff;
	logic [7:0] held [MAX_LEN];
	logic [7:0] stage [MAX_LEN];
	logic [5:0] held_len_ff;
	assign axi_s = axi_ff;
	assign request_to_send_out = rts_ff;

	// ==========================================================
	// line receiver
	bcr_uart_e u_st_ff;
	bcr_uart_e nxt_u_st;
	logic [15:0] u_cnt_ff;
	logic [15:0] nxt_u_cnt;
	logic [7:0] sh_ff;
	logic [7:0] nxt_sh;
	logic [2:0] bits_ff;
	logic [2:0] nxt_bits;
	logic par_ff;
	logic nxt_par;
	logic bad_ff;
	logic nxt_bad;
	logic stops_ff;
	logic nxt_stops;
	logic rx_prev_ff;
	logic u_done;
	logic u_err;
	wire [15:0] bit_cyc = (cfg_ff.baud == BAUD_SEL_LO) ? 16'(BIT_CYC_4800) :
		(cfg_ff.baud == BAUD_SEL_HI) ? 16'(BIT_CYC_19200) : 16'(BIT_CYC_9600);
	wire u_tick = u_cnt_ff == 16'h0000;
	wire [2:0] last_bit = cfg_ff.eight_bits ? 3'h7 : 3'h6;
	wire [7:0] u_byte = cfg_ff.eight_bits ? sh_ff : {1'b0, sh_ff[7:1]};
	wire par_ok = (par_ff ^ rxd_in) == (cfg_ff.parity == PAR_ODD);

	always_comb begin
		nxt_u_st = u_st_ff;
		nxt_u_cnt = u_tick ? 16'h0000 : u_cnt_ff - 16'h0001;
		nxt_sh = sh_ff;
		nxt_bits = bits_ff;
		nxt_par = par_ff;
		nxt_bad = bad_ff;
		nxt_stops = stops_ff;
		u_done = 1'b0;
		u_err = 1'b0;
		case (u_st_ff)
			U_IDLE: if (rx_prev_ff && !rxd_in) begin
				nxt_u_st = U_START;
				nxt_u_cnt = bit_cyc >> 1;
			end
			U_START: if (u_tick) begin
				// a glitch shorter than half a bit is not a start bit
				nxt_u_st = rxd_in ? U_IDLE : U_DATA;
				nxt_u_cnt = bit_cyc - 16'h0001;
				nxt_bits = 3'h0;
				nxt_par = 1'b0;
				nxt_bad = 1'b0;
				nxt_stops = 1'b0;
			end
			U_DATA: if (u_tick) begin
				nxt_sh = {rxd_in, sh_ff[7:1]};
				nxt_par = par_ff ^ rxd_in;
				nxt_bits = bits_ff + 3'h1;
				nxt_u_cnt = bit_cyc - 16'h0001;
				if (bits_ff == last_bit) begin
					nxt_u_st = (cfg_ff.parity == PAR_NONE) ? U_STOP : U_PAR;
				end
			end
			U_PAR: if (u_tick) begin
				nxt_bad = bad_ff || !par_ok;
				nxt_u_cnt = bit_cyc - 16'h0001;
				nxt_u_st = U_STOP;
			end
			U_STOP: if (u_tick) begin
				nxt_u_cnt = bit_cyc - 16'h0001;
				if (cfg_ff.two_stop && !stops_ff) begin
					nxt_stops = 1'b1;
					nxt_bad = bad_ff || !rxd_in;
				end else begin
					nxt_u_st = U_IDLE;
					u_done = rxd_in && !bad_ff;
					u_err = !rxd_in || bad_ff;
				end
			end
			default: nxt_u_st = U_IDLE;
		endcase
		if (!cfg_ff.enable) begin
			nxt_u_st = U_IDLE;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			u_st_ff <= U_IDLE;
			u_cnt_ff <= 16'h0000;
			sh_ff <= 8'h00;
			bits_ff <= 3'h0;
			par_ff <= 1'b0;
			bad_ff <= 1'b0;
			stops_ff <= 1'b0;
			rx_prev_ff <= 1'b1;
		end else begin
			u_st_ff <= nxt_u_st;
			u_cnt_ff <= nxt_u_cnt;
			sh_ff <= nxt_sh;
			bits_ff <= nxt_bits;
			par_ff <= nxt_par;
			bad_ff <= nxt_bad;
			stops_ff <= nxt_stops;
			rx_prev_ff <= rxd_in;
		end
	end

	// ==========================================================
	// byte fifo between line and frame checker
	logic fq_in_ready;
	logic fq_valid;
	logic [7:0] fq_byte;
	logic copy_busy_ff;
	wire f_ready = !copy_busy_ff;
	bcr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(u_done),
		.in_data(u_byte),
		.in_ready(fq_in_ready),
		.out_valid(fq_valid),
		.out_data(fq_byte),
		.out_ready(f_ready)
	);

	// ==========================================================
	// frame checker
	bcr_frm_e f_st_ff;
	logic [5:0] f_len_ff;
	logic [5:0] copy_idx_ff;
	logic [5:0] copy_len_ff;
	wire f_pop = fq_valid && f_ready;
	wire in_frame = f_st_ff == F_TAKE;
	wire is_stx = fq_byte == STX_CHAR;
	wire is_etx = fq_byte == ETX_CHAR;
	wire in_range = fq_byte >= CHAR_MIN && fq_byte <= CHAR_MAX;
	wire room = f_len_ff < 6'(MAX_LEN);
	wire pop_stx = f_pop && is_stx;
	wire pop_etx = f_pop && in_frame && is_etx;
	wire pop_store = f_pop && in_frame && !is_stx && !is_etx && in_range && room;
	wire pop_bad = f_pop && in_frame && !is_stx && !is_etx && !(in_range && room);
	wire line_abort = u_err && in_frame && !pop_etx && !pop_stx;
	wire copy_done = copy_busy_ff && copy_idx_ff == copy_len_ff;

	always_ff @(posedge core_clk) begin
		if (pop_store) stage[f_len_ff] <= fq_byte;
		if (copy_busy_ff && !copy_done) held[copy_idx_ff] <= stage[copy_idx_ff];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			f_st_ff <= F_HUNT;
			f_len_ff <= 6'h00;
			copy_busy_ff <= 1'b0;
			copy_idx_ff <= 6'h00;
			copy_len_ff <= 6'h00;
			held_len_ff <= 6'h00;
		end else begin
			if (pop_stx) begin
				f_st_ff <= F_TAKE;
				f_len_ff <= 6'h00;
			end else if (pop_etx) begin
				f_st_ff <= F_HUNT;
				copy_busy_ff <= 1'b1;
				copy_idx_ff <= 6'h00;
				copy_len_ff <= f_len_ff;
			end else if (pop_bad || line_abort) begin
				f_st_ff <= F_HUNT;
			end else if (pop_store) begin
				f_len_ff <= f_len_ff + 6'h01;
			end
			if (copy_done) begin
				copy_busy_ff <= 1'b0;
				held_len_ff <= copy_len_ff;
			end else if (copy_busy_ff) begin
				copy_idx_ff <= copy_idx_ff + 6'h01;
			end
		end
	end

	// ==========================================================
	// register decode
	logic aw_got_ff;
	logic w_got_ff;
	logic [11:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	wire wr_fire = aw_got_ff && w_got_ff && !axi_ff.bvalid;
	wire wr_ctrl = waddr_ff == OFS_CTRL;
	wire wr_stat = waddr_ff == OFS_STATUS;
	wire wr_ack = waddr_ff == OFS_ACK;
	wire wr_lo = wr_fire && wstrb_ff[0];
	wire w1c_disc = wr_lo && wr_stat && wdata_ff[ST_DISCARD];
	wire w1c_ovr = wr_lo && wr_stat && wdata_ff[ST_OVERRUN];
	wire w1c_line = wr_lo && wr_stat && wdata_ff[ST_LINE_ERR];
	wire ack_host = wr_lo && wr_ack && wdata_ff[0];
	wire ar_fire = axi_m.arvalid && axi_ff.arready;
	wire [11:0] ra = axi_m.araddr;
	wire rd_str = ra[11:8] == OFS_STR_PAGE && ra[7:2] < 6'(MAX_LEN) && ra[1:0] == 2'h0;
	wire rd_ctrl = ra == OFS_CTRL;
	wire rd_stat = ra == OFS_STATUS;
	wire [31:0] stat_word = {18'h0, held_len_ff, 1'b0, copy_busy_ff, line_err_ff, overrun_ff,
		discard_ff, cts_in, rts_ff, str_valid_ff};
	wire [31:0] rd_word = rd_ctrl ? {24'h0, cfg_ff} : rd_stat ? stat_word :
		rd_str ? {24'h0, held[ra[7:2]]} : 32'h0;
	wire rd_ok = rd_ctrl || rd_stat || rd_str || ra == OFS_ACK;
	wire rts_next = cfg_ff.enable && !(cfg_ff.auto_mode && str_valid_ff);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			axi_ff <= '0;
			axi_ff.awready <= 1'b1;
			axi_ff.wready <= 1'b1;
			axi_ff.arready <= 1'b1;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			waddr_ff <= 12'h000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (axi_m.awvalid && axi_ff.awready) begin
				aw_got_ff <= 1'b1;
				waddr_ff <= axi_m.awaddr;
				axi_ff.awready <= 1'b0;
			end
			if (axi_m.wvalid && axi_ff.wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= axi_m.wdata;
				wstrb_ff <= axi_m.wstrb;
				axi_ff.wready <= 1'b0;
			end
			if (wr_fire) begin
				axi_ff.bvalid <= 1'b1;
				axi_ff.bresp <= (wr_ctrl || wr_stat || wr_ack) ? RESP_OKAY : RESP_SLVERR;
			end
			if (axi_ff.bvalid && axi_m.bready) begin
				axi_ff.bvalid <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				axi_ff.awready <= 1'b1;
				axi_ff.wready <= 1'b1;
			end
			if (ar_fire) begin
				axi_ff.arready <= 1'b0;
				axi_ff.rvalid <= 1'b1;
				axi_ff.rdata <= rd_word;
				axi_ff.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (axi_ff.rvalid && axi_m.rready) begin
				axi_ff.rvalid <= 1'b0;
				axi_ff.arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// control, status and flow control
	// event sets win over software clears so a coincident event is kept
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= CFG_RST;
			rts_ff <= 1'b0;
			str_valid_ff <= 1'b0;
			discard_ff <= 1'b0;
			overrun_ff <= 1'b0;
			line_err_ff <= 1'b0;
		end else begin
			if (wr_lo && wr_ctrl) cfg_ff <= wdata_ff[7:0];
			rts_ff <= rts_next;
			// overwrite regardless of whether the host saw the last string
			str_valid_ff <= copy_done || (str_valid_ff && !ack_host);
			discard_ff <= pop_bad || line_abort || (discard_ff && !w1c_disc);
			overrun_ff <= (u_done && !fq_in_ready) || (overrun_ff && !w1c_ovr);
			line_err_ff <= u_err || (line_err_ff && !w1c_line);
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_etx_pop;
		pop_etx;
	endsequence
	sequence s_copy_run;
		copy_busy_ff ##1 copy_busy_ff;
	endsequence
	a_auto_rts_drop: assert property (
		(cfg_ff.auto_mode && str_valid_ff && !ack_host) ##1 cfg_ff.auto_mode |=> !request_to_send_out)
		else $error("request to send still on with string pending");
	a_manual_rts_on: assert property (
		(cfg_ff.enable && !cfg_ff.auto_mode) [*2] |=> request_to_send_out)
		else $error("request to send off in manual mode");
	a_port_off_idle: assert property (
		!cfg_ff.enable |=> u_st_ff == U_IDLE && !u_done && !request_to_send_out)
		else $error("receiver active while port not selected");
	a_stx_restart: assert property (
		pop_stx |=> f_st_ff == F_TAKE && f_len_ff == 6'h00)
		else $error("stx did not restart collection");
	a_len_limit: assert property (f_len_ff <= 6'(MAX_LEN))
		else $error("frame length above limit");
	a_bad_char_drop: assert property (
		(f_pop && in_frame && !is_stx && !is_etx && !in_range) |=> f_st_ff == F_HUNT && !copy_busy_ff)
		else $error("out of range character kept");
	a_etx_commit: assert property (
		s_etx_pop |=> copy_busy_ff && copy_len_ff == $past(f_len_ff))
		else $error("etx did not start delivery");
	a_copy_stalls: assert property (
		s_copy_run |-> !f_pop && copy_idx_ff == $past(copy_idx_ff) + 6'h01)
		else $error("frame checker consumed bytes during delivery");
	a_deliver_flag: assert property (
		copy_done |=> str_valid_ff && held_len_ff == $past(copy_len_ff))
		else $error("delivered string not flagged");
	a_seven_bit: assert property (
		(u_done && !cfg_ff.eight_bits) |-> !u_byte[7])
		else $error("seven bit character has bit 7 set");
	a_bit_period: assert property (
		(u_st_ff == U_DATA && u_tick && cfg_ff.baud == BAUD_SEL_MID) |=> u_cnt_ff == 16'(BIT_CYC_9600 - 1))
		else $error("bit period reload wrong");
endmodule
`default_nettype wire

/* File: verif/bcr_reader_model.sv */
// bar code reader model: sends STX/ETX framed strings on the serial line, LSB first
// assumes the bench hands it the bit period in core clock cycles and the line format
`default_nettype none
module bcr_reader_model
	import bcr_pkg::*;
(
	// clock
	input wire logic core_clk,
	// serial link
	input wire logic rts_in,
	output logic txd_out,
	output logic cts_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// line idles at mark level between characters
	initial begin
		txd_out = 1'b1;
		cts_out = 1'b1;
	end
	task automatic put_bit(input logic v, input int cyc);
		@(posedge core_clk);
		txd_out <= v;
		repeat (cyc - 1) @(posedge core_clk);
	endtask
	// same data bits, parity and stop bits as the receiver is set to
	task automatic send_byte(input logic [7:0] b, input int cyc, input logic eight,
		input logic [1:0] par, input logic two);
		logic p;
		p = eight ? ^b : ^b[6:0];
		put_bit(1'b0, cyc);
		for (int i = 0; i < (eight ? 8 : 7); i++) begin
			put_bit(b[i], cyc);
		end
		if (par == PAR_ODD) begin
			put_bit(~p, cyc);
		end else if (par == PAR_EVEN) begin
			put_bit(p, cyc);
		end
		put_bit(1'b1, cyc);
		if (two) begin
			put_bit(1'b1, cyc);
		end
	endtask
	// ==========================================================
	// plain framing; holds off while request-to-send is low unless the cable is looped
	task automatic send_frame(input logic [7:0] q[$], input int cyc, input logic eight,
		input logic [1:0] par, input logic two, input logic looped);
		int w;
		foreach (q[k]) begin
			w = 0;
			while (!rts_in && !looped && w < 100000) begin
				@(posedge core_clk);
				w++;
			end
			send_byte(q[k], cyc, eight, par, two);
		end
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_barcode_serial_receiver.sv */
// testbench for the bar code serial receiver: register bus master plus reader model
// assumes shortened bit periods; every expectation is worked out from the bench's own values
`default_nettype none
module tb_barcode_serial_receiver;
	import bcr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC_LO = 64;
	localparam int CYC_MID = 32;
	localparam int CYC_HI = 16;
	logic core_clk;
	logic rst;
	bcr_axi_m_s m;
	bcr_axi_s_s s;
	wire rxd;
	wire cts;
	wire rts;
	int mismatches;
	int samples_checked;
	int cyc;
	logic eight;
	logic two;
	logic [1:0] par;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [7:0] q[$];
	// ==========================================================
	// design and far side
	bcr_rx #(.BIT_CYC_4800(CYC_LO), .BIT_CYC_9600(CYC_MID), .BIT_CYC_19200(CYC_HI),
		.FIFO_DEPTH(4)) u_dut (.core_clk(core_clk), .rst(rst), .axi_m(m), .axi_s(s),
		.rxd_in(rxd), .cts_in(cts), .request_to_send_out(rts));
	bcr_reader_model u_reader (.core_clk(core_clk), .rts_in(rts), .txd_out(rxd), .cts_out(cts));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		m.awvalid <= 1'b1;
		m.awaddr <= a;
		m.wvalid <= 1'b1;
		m.wdata <= d;
		m.wstrb <= 4'hF;
		m.bready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (m.awvalid && s.awready) m.awvalid <= 1'b0;
			if (m.wvalid && s.wready) m.wvalid <= 1'b0;
			if (m.bready && s.bvalid) begin
				rsp = s.bresp;
				m.bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic axi_rd(input logic [11:0] a);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		m.arvalid <= 1'b1;
		m.araddr <= a;
		m.rready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (m.arvalid && s.arready) m.arvalid <= 1'b0;
			if (m.rready && s.rvalid) begin
				rd = s.rdata;
				rsp = s.rresp;
				m.rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic set_cfg(input logic au, input logic [1:0] bd, input logic [1:0] pa,
		input logic tw, input logic ei);
		bcr_cfg_s c;
		c = '{auto_mode: au, baud: bd, parity: pa, two_stop: tw, eight_bits: ei, enable: 1'b1};
		cyc = (bd == BAUD_SEL_LO) ? CYC_LO : (bd == BAUD_SEL_HI) ? CYC_HI : CYC_MID;
		par = pa;
		two = tw;
		eight = ei;
		axi_wr(OFS_CTRL, {24'h0, c});
	endtask
	task automatic mkq(input logic [7:0] d[$]);
		q = {STX_CHAR};
		q = {q, d};
		q.push_back(ETX_CHAR);
	endtask
	// extra idle time covers the delivery copy after the end byte
	task automatic frame(input logic looped);
		u_reader.send_frame(q, cyc, eight, par, two, looped);
		repeat (4 * cyc) @(posedge core_clk);
	endtask
	task automatic rd_status();
		axi_rd(OFS_STATUS);
	endtask
	// held string must match, then the host acknowledges it
	task automatic chk_str(input logic [7:0] d[$]);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h1);
		check(32'(rd[13:8]), 32'(d.size()));
		foreach (d[i]) begin
			axi_rd({OFS_STR_PAGE, 8'h00} + 12'(4 * i));
			check(rd, {24'h0, d[i]});
		end
		axi_wr(OFS_ACK, 32'h1);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		axi_rd(OFS_CTRL);
		check(rd, 32'h34);
		check(32'(rsp), 32'(RESP_OKAY));
		check(32'(rts), 32'h0);
		axi_rd(12'hFFC);
		check(32'(rsp), 32'(RESP_SLVERR));
		axi_wr(12'hFFC, 32'h0);
		check(32'(rsp), 32'(RESP_SLVERR));
		cyc = CYC_MID;
		eight = 1'b0;
		par = PAR_EVEN;
		two = 1'b1;
		mkq('{8'h41});
		frame(1'b1);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h0);
		check(32'(rd[ST_RTS]), 32'h0);
		$display("test reset done");
	endtask
	task automatic t_formats();
		for (int i = 0; i < 6; i++) begin
			set_cfg(1'b0, 2'(i % 3), 2'((i + 1) % 3), i[0], i[1]);
			rd_status();
			check(32'(rd[ST_RTS]), 32'h1);
			check(32'(rd[ST_CTS]), 32'h1);
			mkq('{i[0] ? CHAR_MAX : CHAR_MIN});
			frame(1'b0);
			chk_str('{i[0] ? CHAR_MAX : CHAR_MIN});
		end
		$display("test formats done");
	endtask
	task automatic t_bad();
		logic [7:0] d[$];
		set_cfg(1'b0, BAUD_SEL_HI, PAR_NONE, 1'b0, 1'b1);
		mkq('{8'h41, 8'h1F, 8'h42});
		frame(1'b0);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h0);
		check(32'(rd[ST_DISCARD]), 32'h1);
		axi_wr(OFS_STATUS, 32'h8);
		for (int i = 0; i < 41; i++) begin
			d.push_back(8'h30 + 8'(i));
		end
		mkq(d);
		frame(1'b0);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h0);
		check(32'(rd[ST_DISCARD]), 32'h1);
		axi_wr(OFS_STATUS, 32'h8);
		void'(d.pop_back());
		mkq(d);
		frame(1'b0);
		chk_str(d);
		mkq('{8'h51});
		void'(q.pop_front());
		frame(1'b0);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h0);
		mkq('{8'h58, STX_CHAR, 8'h59});
		frame(1'b0);
		chk_str('{8'h59});
		$display("test bad frames done");
	endtask
	task automatic t_auto();
		set_cfg(1'b1, BAUD_SEL_HI, PAR_EVEN, 1'b1, 1'b0);
		mkq('{8'h41, 8'h42});
		frame(1'b0);
		rd_status();
		check(32'(rd[ST_RTS]), 32'h0);
		check(32'(rts), 32'h0);
		// looped cable: the next string still lands over the unreported one
		mkq('{8'h43});
		frame(1'b1);
		chk_str('{8'h43});
		repeat (4) @(posedge core_clk);
		rd_status();
		check(32'(rd[ST_RTS]), 32'h1);
		// a parity fault inside a frame drops the frame and flags the line
		u_reader.send_frame('{STX_CHAR, 8'h44}, cyc, eight, par, two, 1'b0);
		u_reader.send_frame('{8'h45}, cyc, eight, PAR_ODD, two, 1'b0);
		q = '{ETX_CHAR};
		frame(1'b0);
		rd_status();
		check(32'(rd[ST_VALID]), 32'h0);
		check(32'(rd[ST_LINE_ERR]), 32'h1);
		check(32'(rd[ST_DISCARD]), 32'h1);
		$display("test auto trigger done");
	endtask
	// ==========================================================
	// run control
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		m = '0;
		rst = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_formats();
		t_bad();
		t_auto();
		final_report();
	end
	// the tests need about 30k cycles; give up at 60k
	initial begin
		#600_000;
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire
